// ### temp_result_formatter.sv
module temp_result_formatter
	import temp_pkg::*;
#(
	parameter int CONV_TIME_CYCLES = CONV_CYCLES
)(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [9:0]  localCode,
	input  wire logic        localValid,
	input  wire logic [10:0] remoteCode,
	input  wire logic        strapUpSense,
	input  wire logic        strapDownSense,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regRead,
	output logic             biasHigh,
	output logic             remoteSampleTick,
	output logic      [7:0]  regData,
	output logic      [6:0]  busAddress,
	output logic             busAddressValid
);
	localparam int MEAS_CYCLES = CONV_TIME_CYCLES / AVG_COUNT;
	localparam int HALF_CYCLES = MEAS_CYCLES / 2;
	localparam int PW          = $clog2(MEAS_CYCLES);
	localparam int GW          = $clog2(CONV_TIME_CYCLES + 1);

	logic [PW-1:0]       phaseCount;
	logic [PW-1:0]       next_phaseCount;
	logic                next_biasHigh;
	logic                endMeas;
	logic signed [14:0]  acc;
	logic signed [14:0]  next_acc;
	logic signed [14:0]  sum;
	logic [3:0]          avgCount;
	logic [3:0]          next_avgCount;
	logic [10:0]         avg;
	logic [10:0]         clamped;
	logic                lastMeas;
	temp_result_t        localRes;
	temp_result_t        next_localRes;
	temp_result_t        remoteRes;
	temp_result_t        next_remoteRes;
	logic                remoteUpdate;
	logic [7:0]          next_regData;

	strap_sampler strapInst (
		.clock          (clock),
		.rst_n          (rst_n),
		.strapUpSense   (strapUpSense),
		.strapDownSense (strapDownSense),
		.busAddress     (busAddress),
		.busAddressValid(busAddressValid)
	);

	// measurement sequencer: low bias first half, high bias second half
	always_comb begin
		endMeas         = (phaseCount == PW'(MEAS_CYCLES - 1));
		next_phaseCount = endMeas ? '0 : phaseCount + PW'(1); // [RULE9]
		next_biasHigh   = biasHigh;
		if (phaseCount == PW'(HALF_CYCLES - 1))
			next_biasHigh = 1'b1; // [RULE10]
		else if (endMeas)
			next_biasHigh = 1'b0; // [RULE10]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phaseCount       <= '0;
			biasHigh         <= 1'b0;
			remoteSampleTick <= 1'b0;
		end else begin
			phaseCount       <= next_phaseCount;
			biasHigh         <= next_biasHigh;
			remoteSampleTick <= endMeas;
		end
	end

	// averaging: sixteen samples summed, then an arithmetic shift
	always_comb begin
		lastMeas      = (avgCount == 4'(AVG_COUNT - 1));
		sum           = acc + {{4{remoteCode[10]}}, remoteCode}; // [RULE2]
		avg           = sum[AVG_SHIFT +: 11]; // [RULE8]
		// the remote range stops at -127 C, so pin anything lower there
		clamped       = ($signed(avg) < $signed(REMOTE_MIN)) ? REMOTE_MIN : avg; // [RULE11]
		remoteUpdate  = endMeas && lastMeas;
		next_acc      = acc;
		next_avgCount = avgCount;
		if (endMeas) begin
			next_acc      = lastMeas ? '0 : sum; // [RULE8]
			next_avgCount = avgCount + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc      <= '0;
			avgCount <= 4'h0;
		end else begin
			acc      <= next_acc;
			avgCount <= next_avgCount;
		end
	end

	// whole byte and fraction move in one write, but the high-byte and extended-register reads are separate and can straddle an update
	always_comb begin
		next_localRes  = localRes;
		next_remoteRes = remoteRes;
		if (localValid)
			next_localRes = '{high: localCode[9:2], frac: {localCode[1:0], 1'b0}}; // [RULE1] [RULE6] [RULE15]
		if (remoteUpdate)
			next_remoteRes = '{high: clamped[10:3], frac: clamped[2:0]}; // [RULE3] [RULE4] [RULE5] [RULE15]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			localRes  <= '0;
			remoteRes <= '0;
		end else begin
			localRes  <= next_localRes;
			remoteRes <= next_remoteRes;
		end
	end

	// read port: data holds until the next read
	always_comb begin
		next_regData = regData;
		if (regRead) begin
			unique case (regAddr)
				REG_LOCAL_HIGH:  next_regData = localRes.high; // [RULE4]
				REG_REMOTE_HIGH: next_regData = remoteRes.high; // [RULE4]
				REG_EXT_RES: begin
					next_regData = REG_RESERVED;
					next_regData[EXT_REMOTE_LSB +: 3] = remoteRes.frac; // [RULE7]
					next_regData[EXT_LOCAL_LSB +: 2]  = localRes.frac[2:1]; // [RULE7]
				end
				default:         next_regData = REG_RESERVED;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			regData <= 8'h00;
		else
			regData <= next_regData;
	end

	// helper: cycles since last remote update
	logic [GW-1:0] gapCount;
	logic          seenUpdate;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gapCount   <= '0;
			seenUpdate <= 1'b0;
		end else begin
			gapCount   <= remoteUpdate ? '0 : gapCount + GW'(1);
			seenUpdate <= seenUpdate | remoteUpdate;
		end
	end

	// separate tally of samples, so a wrong averaging count cannot hide behind avgCount
	logic [4:0] sampleCount;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			sampleCount <= 5'h00;
		else if (remoteUpdate)
			sampleCount <= 5'h00;
		else if (endMeas)
			sampleCount <= sampleCount + 5'h01;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence localTaken;
		localValid;
	endsequence
	sequence remoteDone;
		endMeas && lastMeas;
	endsequence
	sequence sampleTaken;
		endMeas;
	endsequence
	sequence biasLowAgain;
		remoteSampleTick && !biasHigh;
	endsequence

	localSplit_a: assert property ( // [RULE1] [RULE6]
		localTaken |=> localRes.high == $past(localCode[9:2]) && localRes.frac[2:1] == $past(localCode[1:0]))
		else $error("local result split wrong");
	remoteOnlyAvg_a: assert property ( // [RULE15]
		!remoteUpdate |=> $stable(remoteRes))
		else $error("remote result changed outside averaging end");
	remoteFrac_a: assert property ( // [RULE5] [RULE3]
		remoteDone |=> remoteRes.frac == $past(clamped[2:0]) && remoteRes.high == $past(clamped[10:3]))
		else $error("remote result packing wrong");
	avgCount_a: assert property ( // [RULE8]
		remoteUpdate |-> sampleCount == 5'(AVG_COUNT - 1))
		else $error("remote update not after sixteen samples");
	sampleTick_a: assert property ( // [RULE10]
		sampleTaken |=> biasLowAgain)
		else $error("sample tick or bias return missing");
	readHold_a: assert property ( // [RULE7]
		!regRead |=> $stable(regData))
		else $error("read data moved without a read");
	localHold_a: assert property ( // [RULE15]
		!localValid |=> $stable(localRes))
		else $error("local result changed without a strobe");
	extReserved_a: assert property ( // [RULE7]
		regRead && regAddr == REG_EXT_RES |=> regData[2:0] == 3'h0)
		else $error("unused fraction register bits set");
	convPeriod_a: assert property ( // [RULE9]
		remoteUpdate && seenUpdate |-> gapCount == GW'(MEAS_CYCLES * AVG_COUNT - 1))
		else $error("conversion period wrong");
	biasToggle_a: assert property ( // [RULE10]
		$changed(biasHigh) |-> $past(phaseCount) == PW'(HALF_CYCLES - 1) || $past(endMeas))
		else $error("bias changed at wrong time");
	remoteFloor_a: assert property ( // [RULE11]
		$signed({remoteRes.high, remoteRes.frac}) >= $signed(REMOTE_MIN))
		else $error("remote result below floor");
	extPacking_a: assert property ( // [RULE7]
		regRead && regAddr == REG_EXT_RES |=>
			regData[EXT_REMOTE_LSB +: 3] == $past(remoteRes.frac) && regData[EXT_LOCAL_LSB +: 2] == $past(localRes.frac[2:1]))
		else $error("extended register packing wrong");
	wholeByte_a: assert property ( // [RULE4]
		regRead && regAddr == REG_REMOTE_HIGH |=> regData == $past(remoteRes.high))
		else $error("remote whole byte read wrong");
endmodule

// ### temp_pkg.sv
// Behaviour
// RULE1 - local result is 10-bit two's complement, LSB worth 0.25 C
// RULE2 - remote result is 11-bit two's complement
// RULE3 - remote converter LSB is worth 0.125 C
// RULE4 - whole degrees of both channels form an 8-bit two's complement byte
// RULE5 - remote fraction is 3 bits, 0.125 C per code step
// RULE6 - local fraction is 2 bits, 0.25 C per code step
// RULE7 - both fractions sit together in the extended resolution fractional_temperature_bits
// RULE8 - each remote result averages 16 successive measurement cycles
// RULE9 - one complete remote conversion nominally takes 9.6 ms
// RULE10 - bias alternates between base current and N times base during measurement
// RULE11 - remote result spans -127 C to +127.75 C; the code clamps only the low end, so results reach +127.875 C
// RULE12 - three-state strap sampled only at power-up, sets two address LSBs
// RULE13 - upper five address bits fixed at 01011, later strap changes ignored
// RULE14 - strap low gives 00, open gives 10, supply gives 01
// RULE15 - whole byte and fraction of a channel update together after averaging
package temp_pkg;
	localparam int        CLOCK_HZ        = 100_000_000;
	localparam real       CONV_TIME_MS    = 9.6;
	localparam int        CONV_CYCLES     = int'(CONV_TIME_MS * CLOCK_HZ / 1000.0);
	localparam int        AVG_COUNT       = 16;
	localparam int        AVG_SHIFT       = 4;
	localparam int        STRAP_SETTLE    = 8;

	localparam logic [7:0] REG_LOCAL_HIGH  = 8'h00;
	localparam logic [7:0] REG_REMOTE_HIGH = 8'h01;
	localparam logic [7:0] REG_EXT_RES     = 8'h06;
	localparam logic [7:0] REG_RESERVED    = 8'h00;

	localparam int        EXT_REMOTE_LSB  = 5;
	localparam int        EXT_LOCAL_LSB   = 3;

	localparam logic [10:0] REMOTE_MIN    = 11'h408;
	localparam logic [4:0]  ADDR_UPPER    = 5'h0B;
	localparam logic [1:0]  STRAP_LOW     = 2'h0;
	localparam logic [1:0]  STRAP_OPEN    = 2'h2;
	localparam logic [1:0]  STRAP_HIGH    = 2'h1;

	typedef struct packed {
		logic [7:0] high;
		logic [2:0] frac;
	} temp_result_t;
endpackage

// ### strap_sampler.sv
module strap_sampler
	import temp_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       strapUpSense,
	input  wire logic       strapDownSense,
	output logic      [6:0] busAddress,
	output logic            busAddressValid
);
	typedef enum logic {SETTLE, LATCHED} strap_state_t;

	logic [2:0]   upSync;
	logic [2:0]   downSync;
	logic         upLevel;
	logic         downLevel;
	logic         next_upLevel;
	logic         next_downLevel;
	logic [3:0]   settleCount;
	logic [3:0]   next_settleCount;
	strap_state_t state;
	strap_state_t next_state;
	logic [6:0]   next_busAddress;
	logic [1:0]   strapCode;

	// a level only counts once the second and third stages agree
	always_comb begin
		next_upLevel   = (upSync[1] == upSync[2]) ? upSync[2] : upLevel;
		next_downLevel = (downSync[1] == downSync[2]) ? downSync[2] : downLevel;
	end

	always_comb begin
		unique case ({upLevel, downLevel})
			2'b00:   strapCode = STRAP_LOW;  // [RULE14]
			2'b11:   strapCode = STRAP_HIGH; // [RULE14]
			default: strapCode = STRAP_OPEN; // [RULE14]
		endcase
	end

	always_comb begin
		next_state       = state;
		next_settleCount = settleCount;
		next_busAddress  = busAddress;
		unique case (state)
			SETTLE: begin
				if (settleCount == 4'(STRAP_SETTLE - 1)) begin
					next_state      = LATCHED;
					next_busAddress = {ADDR_UPPER, strapCode}; // [RULE12] [RULE13]
				end else begin
					next_settleCount = settleCount + 4'h1;
				end
			end
			// only a fresh reset re-reads the strap
			LATCHED: next_state = LATCHED; // [RULE13]
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			upSync          <= 3'h0;
			downSync        <= 3'h0;
			upLevel         <= 1'b0;
			downLevel       <= 1'b0;
			settleCount     <= 4'h0;
			state           <= SETTLE;
			busAddress      <= 7'h00;
			busAddressValid <= 1'b0;
		end else begin
			upSync          <= {upSync[1:0], strapUpSense};
			downSync        <= {downSync[1:0], strapDownSense};
			upLevel         <= next_upLevel;
			downLevel       <= next_downLevel;
			settleCount     <= next_settleCount;
			state           <= next_state;
			busAddress      <= next_busAddress;
			busAddressValid <= (next_state == LATCHED);
		end
	end

	addrUpper_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE13]
		busAddressValid |-> busAddress[6:2] == ADDR_UPPER)
		else $error("address upper bits wrong");
	addrHold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
		busAddressValid |=> busAddressValid && $stable(busAddress))
		else $error("address changed after latch");
	strapMap_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
		$rose(busAddressValid) |-> busAddress[1:0] == $past(strapCode))
		else $error("strap mapping wrong");
endmodule

// ### remote_diode_model.sv
module remote_diode_model
	import temp_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        biasHigh,
	input  wire logic        remoteSampleTick,
	input  wire logic [10:0] targetCode,
	output logic      [10:0] remoteCode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic jitter;
	logic sawLow;
	logic sawHigh;
	// alternate +0/+1 LSB so any 16 samples average to target plus one half
	// a sample without both bias levels since the last one reads as garbage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			jitter  <= 1'b0;
			sawLow  <= 1'b0;
			sawHigh <= 1'b0;
		end else if (remoteSampleTick) begin
			jitter  <= ~jitter;
			sawLow  <= !biasHigh;
			sawHigh <= biasHigh;
		end else begin
			sawLow  <= sawLow | !biasHigh;
			sawHigh <= sawHigh | biasHigh;
		end
	end
	assign remoteCode = (sawLow && sawHigh) ? targetCode + {10'h000, jitter} : ~targetCode;
endmodule

// ### tb_temp_result_formatter.sv
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_temp_result_formatter
	import temp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CONV = 320;
	localparam int MEAS = CONV / AVG_COUNT;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [9:0]  localCode = 10'h000;
	logic        localValid = 1'b0;
	logic [10:0] remoteCode;
	logic [10:0] targetCode = 11'h000;
	logic        strapUpSense = 1'b0;
	logic        strapDownSense = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic        regRead = 1'b0;
	logic        biasHigh;
	logic        remoteSampleTick;
	logic [7:0]  regData;
	logic [6:0]  busAddress;
	logic        busAddressValid;
	int          errors = 0;
	int          checks = 0;
	logic [1:0]  localFrac = 2'h0;

	always #5 clock = ~clock;

	temp_result_formatter #(.CONV_TIME_CYCLES(CONV)) dut_u (
		.clock(clock), .rst_n(rst_n), .localCode(localCode), .localValid(localValid),
		.remoteCode(remoteCode), .strapUpSense(strapUpSense), .strapDownSense(strapDownSense),
		.regAddr(regAddr), .regRead(regRead), .biasHigh(biasHigh),
		.remoteSampleTick(remoteSampleTick), .regData(regData), .busAddress(busAddress),
		.busAddressValid(busAddressValid));

	remote_diode_model diode_u (
		.clock(clock), .rst_n(rst_n), .biasHigh(biasHigh), .remoteSampleTick(remoteSampleTick),
		.targetCode(targetCode), .remoteCode(remoteCode));

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic hang();
		errors++;
		$display("[ERR] %0t wait ran out", $time);
		print_verdict();
	endtask

	task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clock);
		regRead = 1'b1;
		regAddr = addr;
		@(negedge clock);
		regRead = 1'b0;
		@(negedge clock);
		data = regData;
	endtask

	task automatic waitTicks(input int n);
		int seen;
		seen = 0;
		for (int i = 0; i < n * (MEAS + 5); i++) begin
			@(negedge clock);
			if (remoteSampleTick === 1'b1) seen++;
			if (seen == n) return;
		end
		hang();
	endtask

	task automatic testStrap(input logic up, input logic down, input logic [1:0] low);
		rst_n = 1'b0;
		strapUpSense = up;
		strapDownSense = down;
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		for (int i = 0; i < 20 && busAddressValid !== 1'b1; i++) @(negedge clock);
		if (busAddressValid !== 1'b1) hang();
		`CHK(busAddressValid, 1'b1)
		`CHK(busAddress, {5'h0B, low})
		strapUpSense = ~up;
		strapDownSense = ~down;
		repeat (20) @(negedge clock);
		`CHK(busAddress, {5'h0B, low})
		$display("strap test %b%b done", up, down);
	endtask

	task automatic testLocal(input logic [9:0] code, input logic [7:0] high);
		logic [7:0] d;
		@(negedge clock);
		localCode = code;
		localValid = 1'b1;
		@(negedge clock);
		localValid = 1'b0;
		localFrac = code[1:0];
		readReg(8'h00, d);
		`CHK(d, high)
		readReg(8'h06, d);
		`CHK(d[4:3], code[1:0])
		$display("local test %h done", code);
	endtask

	task automatic testRemote(input logic [10:0] target, input logic [10:0] expResult);
		logic [7:0] d;
		targetCode = target;
		waitTicks(2 * AVG_COUNT + 1);
		readReg(8'h01, d);
		`CHK(d, expResult[10:3])
		readReg(8'h06, d);
		`CHK(d, {expResult[2:0], localFrac, 3'h0})
		$display("remote test %h done", target);
	endtask

	task automatic testCadence();
		int gap;
		int highs;
		logic [7:0] d;
		waitTicks(1);
		gap = 0;
		highs = 0;
		// start inside the tick cycle, so step off it before testing for the next tick
		do begin
			@(negedge clock);
			gap++;
			if (biasHigh === 1'b1) highs++;
		end while (remoteSampleTick !== 1'b1 && gap < 2 * MEAS);
		`CHK(gap, MEAS)
		`CHK(highs, MEAS / 2)
		readReg(8'h07, d);
		`CHK(d, 8'h00)
		$display("cadence test done");
	endtask

	initial begin
		testStrap(1'b0, 1'b0, 2'h0);
		testStrap(1'b1, 1'b0, 2'h2);
		testStrap(1'b1, 1'b1, 2'h1);
		testLocal(10'h39C, 8'hE7);
		testLocal(10'h007, 8'h01);
		testLocal(10'h3FE, 8'hFF);
		testRemote(11'h0CB, 11'h0CB);
		testRemote(11'h7F7, 11'h7F7);
		testRemote(11'h400, 11'h408);
		testCadence();
		print_verdict();
	end
endmodule
